// ---- core/bgio_pkg.sv ----
// Purpose: Shared constants and types for the bidirectional I/O port
// Assumes: AXI4-Lite register access, 32-bit data, one register per word
// Notes:   Offsets, reset values and field positions live here only
package bgio_pkg;

  // Register byte offsets
  localparam logic [5:0] BGIO_OFF_DIR  = 6'h00;
  localparam logic [5:0] BGIO_OFF_PIN  = 6'h04;
  localparam logic [5:0] BGIO_OFF_LAT  = 6'h08;
  localparam logic [5:0] BGIO_OFF_CONV = 6'h0C;
  localparam logic [5:0] BGIO_OFF_CMP  = 6'h10;
  localparam logic [5:0] BGIO_OFF_OSC  = 6'h14;
  localparam int         BGIO_ADDR_W   = 6;

  // Widths
  localparam int BGIO_PINS   = 8;
  localparam int BGIO_CONV_W = 5;
  localparam int BGIO_CMP_W  = 3;
  localparam int BGIO_OSC_W  = 3;

  // Reset values
  localparam logic [7:0]             BGIO_DIR_RST  = 8'hFF;
  localparam logic [7:0]             BGIO_LAT_RST  = 8'h00;
  localparam logic [BGIO_CONV_W-1:0] BGIO_CONV_RST = 5'h1F;
  localparam logic [BGIO_CMP_W-1:0]  BGIO_CMP_RST  = 3'h4;
  localparam logic [BGIO_OSC_W-1:0]  BGIO_OSC_RST  = 3'h0;

  // Comparator control fields
  localparam int BGIO_CMP_OUT1_BIT  = 0;
  localparam int BGIO_CMP_OUT2_BIT  = 1;
  localparam int BGIO_CMP_IN_BIT    = 2;

  // Converter control: bits 3..0 steer pins 0..3, bit 4 steers pin 5
  localparam int BGIO_CONV_PIN5_BIT = 4;

  // Shared pin positions
  localparam int BGIO_PIN_FOUR  = 4;
  localparam int BGIO_PIN_FIVE  = 5;
  localparam int BGIO_PIN_SIX   = 6;
  localparam int BGIO_PIN_SEVEN = 7;

  // Always-GPIO pins 0..5; 6 and 7 depend on oscillator mode
  localparam logic [5:0] BGIO_LOW_IO_MASK = 6'h3F;

  // Bus responses
  localparam logic [1:0] BGIO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BGIO_RESP_SLVERR = 2'h2;

  // Oscillator selection
  typedef enum logic [BGIO_OSC_W-1:0] {
    BGIO_OSC_CRYSTAL,
    BGIO_OSC_EXT_CLKOUT,
    BGIO_OSC_EXT_IO,
    BGIO_OSC_INT_CLKOUT,
    BGIO_OSC_INT_IO
  } bgio_osc_t;

  // Software-visible state
  typedef struct packed {
    logic [7:0]             dir;
    logic [7:0]             lat;
    logic [BGIO_CONV_W-1:0] conv;
    logic [BGIO_CMP_W-1:0]  cmp;
    logic [BGIO_OSC_W-1:0]  osc;
  } bgio_regs_t;

  // Pad drive bundle
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } bgio_pad_t;

endpackage

// ---- core/bgio_port.sv ----
// Purpose: Eight-bit bidirectional I/O port with AXI4-Lite registers
// Assumes: Pin inputs synchronous to aclk after the synchroniser
// Notes:   Pins 6/7 follow the oscillator selection register
//
// Functional notes
// R01: Port has direction, pin-level and output latch registers.
// R02: Eight independent pins, each with its own direction and latch bit.
// R03: Direction bit one makes the pin an input, driver off.
// R04: Direction bit zero drives the latch value onto the pin.
// R05: Pin-level read returns pins; pin-level write updates the latch.
// R06: Latch register reads back latched value for read-modify-write.
// R07: Pin four shared with timer zero clock input and comparator one output.
// R08: Pins six and seven are oscillator or GPIO per oscillator selection.
// R09: Non-GPIO pins six/seven read zero in pin, direction and latch.
// R10: Converter control bits select analog or digital on pins 0-3 and 5.
// R11: Comparator bits claim pins 0-5; software turns comparators off first.
// R12: After reset pins 0-3, 5 analog reading zero; pin four digital input.
// R13: Direction bits still apply in analog mode; software keeps them set.
// R14: Enabled peripheral function keeps the pin from GPIO use; code does so only for the pin six clock output, not comparator outputs.
// R15: Enabled comparator output overrides latch data on its pin.
// R16: Analog function enabled disables the pin's digital input path.
// R17: Pin six is GPIO only in modes leaving it free, else clock use.
// R18: Pin inputs pass a two-stage synchroniser before being read.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps

module bgio_port (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [bgio_pkg::BGIO_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [bgio_pkg::BGIO_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  // Pads
  input  wire logic [7:0]                    pin_in,
  output logic [7:0]                         pin_out,
  output logic [7:0]                         pin_oe,
  // Sharing peripherals
  input  wire logic                          comparator_one_out,
  input  wire logic                          comparator_two_out,
  input  wire logic                          cycle_clock_out,
  output logic                               timer_zero_clock_in,
  output logic [7:0]                         analog_enable
);

  // Register and bus state
  bgio_pkg::bgio_regs_t                regs_r, regs_nxt;
  logic                                aw_held_r, aw_held_nxt;
  logic [bgio_pkg::BGIO_ADDR_W-1:0]    aw_addr_r, aw_addr_nxt;
  logic                                w_held_r, w_held_nxt;
  logic [7:0]                          w_byte_r, w_byte_nxt;
  logic                                w_lane_r, w_lane_nxt;
  logic                                bvalid_r, bvalid_nxt;
  logic [1:0]                          bresp_r, bresp_nxt;
  logic                                rvalid_r, rvalid_nxt;
  logic [31:0]                         rdata_r, rdata_nxt;
  logic [1:0]                          rresp_r, rresp_nxt;

  // Pin state
  logic [7:0]                          sync1_r, sync2_r;
  bgio_pkg::bgio_pad_t                 pad_r, pad_nxt;
  logic [7:0]                          analog_r, analog_nxt;

  // Decoded configuration
  logic                                io6, io7, clko6;
  logic [7:0]                          io_mask;
  logic [7:0]                          analog_sel;
  logic [7:0]                          pin_level;
  logic                                aw_take, w_take, do_write;
  logic [bgio_pkg::BGIO_ADDR_W-1:0]    wr_addr;
  logic [7:0]                          wr_byte;
  logic                                wr_lane;

  // Oscillator selection decode; codes 5..7 fall back to crystal
  always_comb begin
    io6   = 1'b0;
    io7   = 1'b0;
    clko6 = 1'b0;
    unique case (bgio_pkg::bgio_osc_t'(regs_r.osc))
      bgio_pkg::BGIO_OSC_CRYSTAL: begin
        io6 = 1'b0;
      end
      bgio_pkg::BGIO_OSC_EXT_CLKOUT: begin
        clko6 = 1'b1; // [R17]
      end
      bgio_pkg::BGIO_OSC_EXT_IO: begin
        io6 = 1'b1; // [R17]
      end
      bgio_pkg::BGIO_OSC_INT_CLKOUT: begin
        clko6 = 1'b1;
        io7   = 1'b1; // [R08]
      end
      bgio_pkg::BGIO_OSC_INT_IO: begin
        io6 = 1'b1;
        io7 = 1'b1; // [R08]
      end
      default: begin
        io6 = 1'b0;
      end
    endcase
    io_mask = {io7, io6, bgio_pkg::BGIO_LOW_IO_MASK}; // [R08]
  end

  // Analog claims: converter bits and comparator inputs
  always_comb begin
    analog_sel = 8'h00;
    analog_sel[3:0] = regs_r.conv[3:0]
                    | {4{regs_r.cmp[bgio_pkg::BGIO_CMP_IN_BIT]}}; // [R10] [R11]
    analog_sel[bgio_pkg::BGIO_PIN_FIVE] =
      regs_r.conv[bgio_pkg::BGIO_CONV_PIN5_BIT]; // [R10]
    // Digital input killed under analog, and for oscillator pins
    pin_level = sync2_r & ~analog_sel & io_mask; // [R05] [R09] [R16] [R12]
  end

  // Pad drive next state
  always_comb begin
    // Direction still governs analog pins: no override here
    pad_nxt.oe  = ~regs_r.dir & io_mask; // [R03] [R04] [R13] [R02]
    pad_nxt.out = regs_r.lat & io_mask;  // [R04]
    if (regs_r.cmp[bgio_pkg::BGIO_CMP_OUT1_BIT]) begin
      pad_nxt.out[bgio_pkg::BGIO_PIN_FOUR] = comparator_one_out; // [R07] [R15]
    end
    if (regs_r.cmp[bgio_pkg::BGIO_CMP_OUT2_BIT]) begin
      pad_nxt.out[bgio_pkg::BGIO_PIN_FIVE] = comparator_two_out; // [R15]
    end
    // Clock output owns pin six regardless of direction
    if (clko6) begin
      pad_nxt.oe[bgio_pkg::BGIO_PIN_SIX]  = 1'b1; // [R14] [R17]
      pad_nxt.out[bgio_pkg::BGIO_PIN_SIX] = cycle_clock_out;
    end
    analog_nxt = analog_sel;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r    <= 8'h00;
      sync2_r    <= 8'h00;
      pad_r      <= '0;
      analog_r   <= 8'h00;
    end else begin
      sync1_r    <= pin_in;  // [R18]
      sync2_r    <= sync1_r; // [R18]
      pad_r      <= pad_nxt;
      analog_r   <= analog_nxt;
    end
  end

  // Write channel handshake; address and data accepted in either order
  always_comb begin
    s_axi_awready = ~aw_held_r & ~bvalid_r;
    s_axi_wready  = ~w_held_r & ~bvalid_r;
    aw_take  = s_axi_awvalid & s_axi_awready;
    w_take   = s_axi_wvalid & s_axi_wready;
    wr_addr  = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wr_byte  = w_held_r ? w_byte_r : s_axi_wdata[7:0];
    wr_lane  = w_held_r ? w_lane_r : s_axi_wstrb[0];
    do_write = (aw_held_r | aw_take) & (w_held_r | w_take);
  end

  // Write bookkeeping and register update
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_byte_nxt  = w_byte_r;
    w_lane_nxt  = w_lane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    regs_nxt    = regs_r;
    if (aw_take) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (w_take) begin
      w_held_nxt = 1'b1;
      w_byte_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = bgio_pkg::BGIO_RESP_OKAY;
      // Only byte lane 0 carries data; upper lanes are ignored
      unique case (wr_addr)
        bgio_pkg::BGIO_OFF_DIR: begin
          if (wr_lane) regs_nxt.dir = wr_byte; // [R01] [R02]
        end
        bgio_pkg::BGIO_OFF_PIN: begin
          if (wr_lane) regs_nxt.lat = wr_byte; // [R05]
        end
        bgio_pkg::BGIO_OFF_LAT: begin
          if (wr_lane) regs_nxt.lat = wr_byte; // [R01]
        end
        bgio_pkg::BGIO_OFF_CONV: begin
          if (wr_lane) regs_nxt.conv = wr_byte[bgio_pkg::BGIO_CONV_W-1:0]; // [R10]
        end
        bgio_pkg::BGIO_OFF_CMP: begin
          if (wr_lane) regs_nxt.cmp = wr_byte[bgio_pkg::BGIO_CMP_W-1:0]; // [R11]
        end
        bgio_pkg::BGIO_OFF_OSC: begin
          if (wr_lane) regs_nxt.osc = wr_byte[bgio_pkg::BGIO_OSC_W-1:0]; // [R08]
        end
        default: begin
          bresp_nxt = bgio_pkg::BGIO_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Power-on state: all inputs, analog claims on, crystal mode
      regs_r.dir  <= bgio_pkg::BGIO_DIR_RST;  // [R12]
      regs_r.lat  <= bgio_pkg::BGIO_LAT_RST;
      regs_r.conv <= bgio_pkg::BGIO_CONV_RST; // [R12]
      regs_r.cmp  <= bgio_pkg::BGIO_CMP_RST;  // [R12]
      regs_r.osc  <= bgio_pkg::BGIO_OSC_RST;
      aw_held_r   <= 1'b0;
      aw_addr_r   <= '0;
      w_held_r    <= 1'b0;
      w_byte_r    <= 8'h00;
      w_lane_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= bgio_pkg::BGIO_RESP_OKAY;
    end else begin
      regs_r      <= regs_nxt;
      aw_held_r   <= aw_held_nxt;
      aw_addr_r   <= aw_addr_nxt;
      w_held_r    <= w_held_nxt;
      w_byte_r    <= w_byte_nxt;
      w_lane_r    <= w_lane_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
    end
  end

  // Read channel: one outstanding read, answered the next cycle
  always_comb begin
    s_axi_arready = ~rvalid_r;
    rvalid_nxt    = rvalid_r;
    rdata_nxt     = rdata_r;
    rresp_nxt     = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0000_0000;
      rresp_nxt  = bgio_pkg::BGIO_RESP_OKAY;
      unique case (s_axi_araddr)
        bgio_pkg::BGIO_OFF_DIR: begin
          rdata_nxt[7:0] = regs_r.dir & io_mask; // [R09]
        end
        bgio_pkg::BGIO_OFF_PIN: begin
          rdata_nxt[7:0] = pin_level; // [R05]
        end
        bgio_pkg::BGIO_OFF_LAT: begin
          // Latch, not pins: safe for read-modify-write
          rdata_nxt[7:0] = regs_r.lat & io_mask; // [R06] [R09]
        end
        bgio_pkg::BGIO_OFF_CONV: begin
          rdata_nxt[bgio_pkg::BGIO_CONV_W-1:0] = regs_r.conv;
        end
        bgio_pkg::BGIO_OFF_CMP: begin
          rdata_nxt[bgio_pkg::BGIO_CMP_W-1:0] = regs_r.cmp;
        end
        bgio_pkg::BGIO_OFF_OSC: begin
          rdata_nxt[bgio_pkg::BGIO_OSC_W-1:0] = regs_r.osc;
        end
        default: begin
          rresp_nxt = bgio_pkg::BGIO_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= bgio_pkg::BGIO_RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // Outputs
  assign s_axi_bvalid        = bvalid_r;
  assign s_axi_bresp         = bresp_r;
  assign s_axi_rvalid        = rvalid_r;
  assign s_axi_rdata         = rdata_r;
  assign s_axi_rresp         = rresp_r;
  assign pin_out             = pad_r.out;
  assign pin_oe              = pad_r.oe;
  assign timer_zero_clock_in = sync2_r[bgio_pkg::BGIO_PIN_FOUR]; // [R07] [R18]
  assign analog_enable       = analog_r; // [R16]

endmodule // bgio_port

// ---- testbench/bgio_port_sva.sv ----
// Purpose: Assertions on the I/O port ports
// Assumes: One clock, sync active-low reset
// Notes:   Bound to every bgio_port
`timescale 1ns/10ps
module bgio_port_sva (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pads and peripherals
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_oe,
  input wire logic        timer_zero_clock_in,
  input wire logic [7:0]  analog_enable
);
  // Edges since reset; sync chain holds stale data before two
  logic [1:0] up_r;
  logic [1:0] up_nxt;
  always_comb begin
    up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
    if (!aresetn) up_nxt = 2'h0;
  end
  always_ff @(posedge aclk) up_r <= up_nxt;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("no write response");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_bresp_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data changed");
  a_timer_sync: assert property (up_r == 2'h3 |-> timer_zero_clock_in == $past(pin_in[4], 2))
    else $error("timer input not two stages");
  a_oe_reset: assert property (disable iff (1'b0) !aresetn |=> pin_oe == 8'h00)
    else $error("driver on in reset");
  a_analog_boot: assert property (disable iff (1'b0) $rose(aresetn) |=> analog_enable == 8'h2F)
    else $error("analog claim wrong after reset");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_drive: cover property (pin_oe == 8'hFF);
endmodule // bgio_port_sva

bind bgio_port bgio_port_sva u_sva (.*);

// ---- testbench/bgio_pad_model.sv ----
// Purpose: Pads and far side of the I/O port
// Assumes: Bench drives far side via ext_drv/ext_en
// Notes:   No pull resistors, so idle pins toggle
`timescale 1ns/10ps
module bgio_pad_model (
  // Clock
  input wire logic       aclk,
  // Port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Far side
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_en,
  // Resolved level
  output logic [7:0]     pin_in
);
  // Flips each cycle so a stale level never reads back
  logic [7:0] flt_r = 8'h00;
  logic [7:0] flt_nxt;
  always_comb flt_nxt = ~flt_r;
  always_ff @(posedge aclk) flt_r <= flt_nxt;
  // Port driver wins; a disabled driver leaves the pin to others
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
                     | (~pin_oe & ~ext_en & flt_r);
endmodule // bgio_pad_model

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the I/O port
// Assumes: Pad model resolves every pin
// Notes:   Every wait is bounded
`timescale 1ns/10ps
module tb_top;
  localparam logic [5:0] DIR = bgio_pkg::BGIO_OFF_DIR, PIN = bgio_pkg::BGIO_OFF_PIN;
  localparam logic [5:0] LAT = bgio_pkg::BGIO_OFF_LAT, CONV = bgio_pkg::BGIO_OFF_CONV;
  localparam logic [5:0] CMP = bgio_pkg::BGIO_OFF_CMP, OSC = bgio_pkg::BGIO_OFF_OSC;
  localparam logic [1:0] OK = bgio_pkg::BGIO_RESP_OKAY, ERR = bgio_pkg::BGIO_RESP_SLVERR;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, comparator_one_out, comparator_two_out, cycle_clock_out;
  logic        timer_zero_clock_in;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pin_in, pin_out, pin_oe, analog_enable, ext_drv, ext_en;
  int          err_count, comparisons;

  bgio_port uut (.*);
  bgio_pad_model u_pads (.*);

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) cycle_clock_out <= aresetn ? ~cycle_clock_out : 1'h0;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 40) begin
      err_count++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report;
    end
  endtask

  // Ready offered with the request; each valid drops at its own handshake
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int   n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'h0;
    w_done = 1'h0;
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'h1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= 4'h1;
    s_axi_bready  <= 1'h1;
    while (!(aw_done && w_done)) begin
      step(n);
      if (!aw_done && s_axi_awready === 1'h1) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready === 1'h1) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do step(n); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
    // Gap cycle so pads settle and bready never toggles twice in a step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_arvalid <= 1'h1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'h1;
    do step(n); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do step(n); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask

  task automatic t_reset;
    rd(DIR, 8'h3F, OK);
    rd(LAT, 8'h00, OK);
    rd(CONV, 8'h1F, OK);
    rd(CMP, 8'h04, OK);
    rd(PIN, 8'h10, OK);
  endtask

  task automatic t_drive;
    ext_en <= 8'hC0;
    wr(CMP, 8'h00, OK);
    wr(CONV, 8'h00, OK);
    wr(DIR, 8'h00, OK);
    wr(PIN, 8'hB5, OK);
    chk(pin_oe, 8'h3F);
    chk(pin_out[5:0], 6'h35);
    rd(LAT, 8'h35, OK);
    rd(PIN, 8'h35, OK);
  endtask

  task automatic t_digital;
    wr(DIR, 8'hFF, OK);
    ext_en <= 8'hFF;
    ext_drv <= 8'h5A;
    chk(pin_oe, 8'h00);
    wr(CMP, 8'h00, OK);
    wr(CONV, 8'h00, OK);
    chk(analog_enable, 8'h00);
    rd(PIN, 8'h1A, OK);
    wr(OSC, 8'h04, OK);
    rd(PIN, 8'h5A, OK);
    wr(CONV, 8'h1F, OK);
    rd(PIN, 8'h50, OK);
  endtask

  task automatic t_osc;
    int m;
    logic [1:0] e;
    ext_en <= 8'h00;
    wr(LAT, 8'hFF, OK);
    wr(CONV, 8'h00, OK);
    wr(DIR, 8'h00, OK);
    for (m = 0; m < 8; m++) begin
      e = {m == 3 || m == 4, m == 2 || m == 4};
      wr(OSC, m[7:0], OK);
      rd(LAT, {e, 6'h3F}, OK);
      chk(pin_oe[7], e[1]);
      chk(pin_oe[6], e[0] || m == 1 || m == 3);
    end
    wr(OSC, 8'h00, OK);
  endtask

  task automatic t_cmp;
    int v;
    wr(LAT, 8'h00, OK);
    wr(CMP, 8'h03, OK);
    for (v = 0; v < 2; v++) begin
      comparator_one_out <= v[0];
      comparator_two_out <= !v[0];
      repeat (3) @(posedge aclk);
      chk(pin_out[5:4], {!v[0], v[0]});
    end
    comparator_two_out <= 1'h1;
    wr(CMP, 8'h00, OK);
    chk(pin_out[5:4], 2'h0);
  endtask

  task automatic t_timer;
    int v;
    wr(DIR, 8'hFF, OK);
    ext_en <= 8'hFF;
    for (v = 0; v < 2; v++) begin
      ext_drv <= {3'h0, v[0], 4'h0};
      repeat (4) @(posedge aclk);
      chk(timer_zero_clock_in, v[0]);
    end
  endtask

  task automatic t_hole;
    wr(6'h18, 8'h55, ERR);
    rd(6'h18, 8'h00, ERR);
    rd(DIR, 8'h3F, OK);
  endtask

  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 16'h0000;
    s_axi_wdata = 32'h00000000;
    {ext_drv, ext_en} = 16'hFFFF;
    {comparator_one_out, comparator_two_out} = 2'h0;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    chk(analog_enable, 8'h2F);
    t_drive;
    t_digital;
    t_osc;
    t_cmp;
    t_timer;
    t_hole;
    final_report;
  end
endmodule // tb_top
